//--- rtl/clock_prescaler_pkg.sv
// constants, register map and helpers for the clock prescaler and speed-mode block
// assumes a single oscillator-rate clock and a classic wishbone register port
// Contract
// [RL1] reset loads reload value all ones
// [RL2] any 8-bit reload value divides clock
// [RL3] reload zero gives osc/1020 or osc/510
// [RL4] reload all ones gives osc/2 or osc
// [RL5] double-speed: osc over 2*(255-reload)
// [RL6] standard: osc over 4*(255-reload)
// [RL7] double-speed machine cycle is 6 periods
// [RL8] divide-by-2 stage, disabled or bypassed
// [RL9] double-speed change sampled on div2 rise
// [RL10] bit 0 selects 12/6, enables peripheral bits
// [RL11] reset takes double-speed from security byte
// [RL12] peripheral bits act only in double-speed
// [RL13] peripheral bit clear 6, set 12
// [RL14] serial bit affects only modes 0, 2
// [RL15] software never writes bit 7 one
// [RL16] reload register at 97h, resets ones
// [RL17] serial-periph bit 0 at AFh, resets zero
// [RL18] counter reloads on terminal count only
package clock_prescaler_pkg;

    localparam int unsigned WB_ADR_W = 12;
    localparam int unsigned WB_DAT_W = 32;
    localparam int unsigned REG_W = 8;
    localparam int unsigned PERIOD_W = 9;
    localparam int unsigned PHASE_W = 4;

    // register indices; byte address is four times the index
    localparam logic [REG_W-1:0] IDX_SPEED_CONTROL = 8'h8f;
    localparam logic [REG_W-1:0] IDX_RELOAD = 8'h97;
    localparam logic [REG_W-1:0] IDX_SPEED_EXT = 8'haf;
    localparam logic [REG_W-1:0] IDX_DIV_CONTROL = 8'h8e;
    localparam logic [REG_W-1:0] IDX_STATUS = 8'h8d;

    localparam logic [REG_W-1:0] RELOAD_RST = 8'hff;
    localparam logic [REG_W-1:0] RELOAD_FASTEST = 8'hff;
    localparam logic [PERIOD_W-1:0] RELOAD_TOP = 9'h0ff;
    localparam logic [PERIOD_W-1:0] PERIOD_ONE = 9'h001;

    localparam int unsigned BIT_DOUBLE_SPEED = 0;
    localparam int unsigned BIT_TIMER0 = 1;
    localparam int unsigned BIT_TIMER1 = 2;
    localparam int unsigned BIT_TIMER2 = 3;
    localparam int unsigned BIT_SERIAL = 4;
    localparam int unsigned BIT_COUNTER_ARRAY = 5;
    localparam int unsigned BIT_WATCHDOG = 6;
    localparam int unsigned BIT_SERIAL_PERIPH = 0;
    localparam int unsigned BIT_DIV2_BYPASS = 0;
    localparam int unsigned STAT_DOUBLE_SPEED = 0;
    localparam int unsigned STAT_DIV2_ACTIVE = 1;

    localparam logic [REG_W-1:0] SPEED_CONTROL_RST = 8'h00;
    localparam logic [REG_W-1:0] SPEED_CONTROL_WMASK = 8'h7f;
    localparam logic [REG_W-1:0] SPEED_EXT_RST = 8'h00;
    localparam logic [REG_W-1:0] SPEED_EXT_WMASK = 8'h01;
    localparam logic [REG_W-1:0] DIV_CONTROL_RST = 8'h00;
    localparam logic [REG_W-1:0] DIV_CONTROL_WMASK = 8'h01;

    // last cpu-tick phase of the 12-tick slow peripheral cycle, and phases of the fast ones
    localparam logic [PHASE_W-1:0] PHASE_LAST = 4'hb;
    localparam logic [PHASE_W-1:0] PHASE_MID = 4'h5;

    // source ticks between two cpu ticks for a reload value
    function automatic logic [PERIOD_W-1:0] reload_period(input logic [REG_W-1:0] reload);
        logic [PERIOD_W-1:0] span;
        span = RELOAD_TOP - {1'b0, reload};
        if (reload == RELOAD_FASTEST) begin
            return PERIOD_ONE;
        end
        return {span[PERIOD_W-2:0], 1'b0};
    endfunction : reload_period

endpackage : clock_prescaler_pkg

//--- rtl/clock_prescaler_speed_mode.sv
// top of the clock prescaler and speed-mode block, with its wishbone register port
// assumes i_clk is the oscillator clock; outputs other than the bus and o_double_speed are clock-enable strobes for the core
//
// Local design decision: the Wishbone interface to the registers.
`timescale 1ns/100ps
`default_nettype none
module clock_prescaler_speed_mode (
    input wire logic i_clk,
    input wire logic i_srst,
    input wire logic i_hsb_double_speed,
    input wire logic i_wb_cyc,
    input wire logic i_wb_stb,
    input wire logic i_wb_we,
    input wire logic [clock_prescaler_pkg::WB_ADR_W-1:0] i_wb_adr,
    input wire logic [3:0] i_wb_sel,
    input wire logic [clock_prescaler_pkg::WB_DAT_W-1:0] i_wb_dat,
    output logic [clock_prescaler_pkg::WB_DAT_W-1:0] o_wb_dat,
    output logic o_wb_ack,
    output logic o_cpu_clk_en,
    output logic o_periph_clk_en,
    output logic o_machine_cycle,
    output logic o_double_speed,
    output logic o_watchdog_tick,
    output logic o_counter_array_tick,
    output logic o_serial_fixed_tick,
    output logic o_timer0_tick,
    output logic o_timer1_tick,
    output logic o_timer2_tick,
    output logic o_serial_periph_tick
);

    ////////////////////////////////////////////////////////////////////////////////
    // declarations

    logic hsb_meta_r;
    logic hsb_sync_r;
    logic [clock_prescaler_pkg::REG_W-1:0] speed_control_r;
    logic [clock_prescaler_pkg::REG_W-1:0] speed_ext_r;
    logic [clock_prescaler_pkg::REG_W-1:0] div_control_r;
    logic [clock_prescaler_pkg::REG_W-1:0] clock_reload_value_r;
    logic double_speed_active_r;
    logic div2_bypass_active_r;
    logic div2_phase_r;
    logic ack_r;
    logic [clock_prescaler_pkg::WB_DAT_W-1:0] rdata_r;
    logic [clock_prescaler_pkg::REG_W-1:0] rdata_nxt;
    logic [clock_prescaler_pkg::REG_W-1:0] index;
    logic index_hi_zero;
    logic bus_req;
    logic bus_wr;
    logic div2_rise;
    logic src_tick;
    logic fast_sel;
    logic periph_slow;

    clock_tick_if tick ();

    ////////////////////////////////////////////////////////////////////////////////
    // security byte strap synchroniser

    always_ff @(posedge i_clk) begin
        hsb_meta_r <= i_hsb_double_speed;
        hsb_sync_r <= hsb_meta_r;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // wishbone decode

    // upper index bits must be zero, else the address is unmapped
    assign index = i_wb_adr[clock_prescaler_pkg::REG_W+1:2];
    assign index_hi_zero = (i_wb_adr[clock_prescaler_pkg::WB_ADR_W-1:clock_prescaler_pkg::REG_W+2] == '0);
    assign bus_req = i_wb_cyc && i_wb_stb && !ack_r;
    assign bus_wr = bus_req && i_wb_we && i_wb_sel[0] && index_hi_zero;

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            ack_r <= 1'b0;
        end else begin
            ack_r <= bus_req;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // clock speed control register

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            speed_control_r <= clock_prescaler_pkg::SPEED_CONTROL_RST;
            // [RL11] strap from security byte
            speed_control_r[clock_prescaler_pkg::BIT_DOUBLE_SPEED] <= hsb_sync_r;
        end else if (bus_wr && index == clock_prescaler_pkg::IDX_SPEED_CONTROL) begin
            // [RL15] top bit never stored
            speed_control_r <= i_wb_dat[clock_prescaler_pkg::REG_W-1:0] &
                               clock_prescaler_pkg::SPEED_CONTROL_WMASK;
        end
    end

    // [RL17] extension register, serial-periph bit
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            speed_ext_r <= clock_prescaler_pkg::SPEED_EXT_RST;
        end else if (bus_wr && index == clock_prescaler_pkg::IDX_SPEED_EXT) begin
            speed_ext_r <= i_wb_dat[clock_prescaler_pkg::REG_W-1:0] & clock_prescaler_pkg::SPEED_EXT_WMASK;
        end
    end

    // [RL8] software divider bypass
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            div_control_r <= clock_prescaler_pkg::DIV_CONTROL_RST;
        end else if (bus_wr && index == clock_prescaler_pkg::IDX_DIV_CONTROL) begin
            div_control_r <= i_wb_dat[clock_prescaler_pkg::REG_W-1:0] & clock_prescaler_pkg::DIV_CONTROL_WMASK;
        end
    end

    // [RL1] [RL16] reload register, resets ones
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            clock_reload_value_r <= clock_prescaler_pkg::RELOAD_RST;
        end else if (bus_wr && index == clock_prescaler_pkg::IDX_RELOAD) begin
            // [RL2] any 8-bit value
            clock_reload_value_r <= i_wb_dat[clock_prescaler_pkg::REG_W-1:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // read mux

    always_comb begin
        rdata_nxt = '0;
        unique case (index)
            clock_prescaler_pkg::IDX_SPEED_CONTROL: begin
                rdata_nxt = speed_control_r;
            end
            clock_prescaler_pkg::IDX_SPEED_EXT: begin
                rdata_nxt = speed_ext_r;
            end
            clock_prescaler_pkg::IDX_DIV_CONTROL: begin
                rdata_nxt = div_control_r;
            end
            clock_prescaler_pkg::IDX_RELOAD: begin
                rdata_nxt = clock_reload_value_r;
            end
            clock_prescaler_pkg::IDX_STATUS: begin
                rdata_nxt[clock_prescaler_pkg::STAT_DOUBLE_SPEED] = double_speed_active_r;
                rdata_nxt[clock_prescaler_pkg::STAT_DIV2_ACTIVE] =
                    !(double_speed_active_r || div2_bypass_active_r);
            end
            default: begin
                rdata_nxt = '0;
            end
        endcase
        if (!index_hi_zero) begin
            rdata_nxt = '0;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            rdata_r <= '0;
        end else if (bus_req && !i_wb_we) begin
            rdata_r <= {{(clock_prescaler_pkg::WB_DAT_W - clock_prescaler_pkg::REG_W){1'b0}}, rdata_nxt};
        end else begin
            rdata_r <= '0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // divide-by-two stage and glitch-free mode change

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            div2_phase_r <= 1'b0;
        end else begin
            div2_phase_r <= !div2_phase_r;
        end
    end

    // the next edge is the rising edge of the halved clock
    assign div2_rise = !div2_phase_r;

    // [RL9] mode taken on div2 rise
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            double_speed_active_r <= hsb_sync_r;
            div2_bypass_active_r <= 1'b0;
        end else if (div2_rise) begin
            double_speed_active_r <= speed_control_r[clock_prescaler_pkg::BIT_DOUBLE_SPEED];
            div2_bypass_active_r <= div_control_r[clock_prescaler_pkg::BIT_DIV2_BYPASS];
        end
    end

    // [RL8] halved source unless bypassed or in double speed
    // [RL5] [RL6] standard without bypass halves the source
    assign src_tick = double_speed_active_r || div2_bypass_active_r || div2_rise;

    ////////////////////////////////////////////////////////////////////////////////
    // prescaler and phase generator

    assign tick.srst = i_srst;
    assign tick.src_tick = src_tick;
    assign tick.reload = clock_reload_value_r;

    // [RL3] [RL4] divisor from reload period
    prescale_counter u_prescale (
        .i_clk(i_clk),
        .tick(tick)
    );

    cycle_phase_gen u_phase (
        .i_clk(i_clk),
        .tick(tick)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // peripheral speed selection

    // [RL10] [RL12] bits gated by double speed
    function automatic logic periph_tick(input logic active, input logic sel_bit,
                                         input logic fast, input logic slow);
        // [RL13] clear fast, set slow
        return (active && sel_bit) ? slow : fast;
    endfunction : periph_tick

    assign fast_sel = tick.fast_tick;
    assign periph_slow = tick.slow_tick;

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            o_watchdog_tick <= 1'b0;
            o_counter_array_tick <= 1'b0;
            o_serial_fixed_tick <= 1'b0;
            o_timer0_tick <= 1'b0;
            o_timer1_tick <= 1'b0;
            o_timer2_tick <= 1'b0;
            o_serial_periph_tick <= 1'b0;
        end else begin
            o_watchdog_tick <= periph_tick(double_speed_active_r,
                speed_control_r[clock_prescaler_pkg::BIT_WATCHDOG], fast_sel, periph_slow);
            o_counter_array_tick <= periph_tick(double_speed_active_r,
                speed_control_r[clock_prescaler_pkg::BIT_COUNTER_ARRAY], fast_sel, periph_slow);
            // [RL14] serial modes 0, 2 only
            o_serial_fixed_tick <= periph_tick(double_speed_active_r,
                speed_control_r[clock_prescaler_pkg::BIT_SERIAL], fast_sel, periph_slow);
            o_timer0_tick <= periph_tick(double_speed_active_r,
                speed_control_r[clock_prescaler_pkg::BIT_TIMER0], fast_sel, periph_slow);
            o_timer1_tick <= periph_tick(double_speed_active_r,
                speed_control_r[clock_prescaler_pkg::BIT_TIMER1], fast_sel, periph_slow);
            o_timer2_tick <= periph_tick(double_speed_active_r,
                speed_control_r[clock_prescaler_pkg::BIT_TIMER2], fast_sel, periph_slow);
            o_serial_periph_tick <= periph_tick(double_speed_active_r,
                speed_ext_r[clock_prescaler_pkg::BIT_SERIAL_PERIPH], fast_sel, periph_slow);
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // core strobes

    // [RL7] machine cycle of six cpu ticks
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            o_cpu_clk_en <= 1'b0;
            o_periph_clk_en <= 1'b0;
            o_machine_cycle <= 1'b0;
            o_double_speed <= 1'b0;
        end else begin
            o_cpu_clk_en <= tick.cpu_tick;
            o_periph_clk_en <= tick.cpu_tick;
            o_machine_cycle <= fast_sel;
            o_double_speed <= double_speed_active_r;
        end
    end

    assign o_wb_ack = ack_r;
    assign o_wb_dat = rdata_r;

endmodule : clock_prescaler_speed_mode
`default_nettype wire

//--- rtl/clock_tick_if.sv
// tick strobes shared between the clock block and its counter stages
// assumes all members sit on one clock
`timescale 1ns/100ps
`default_nettype none
interface clock_tick_if;
    logic srst;
    logic src_tick;
    logic [clock_prescaler_pkg::REG_W-1:0] reload;
    logic cpu_tick;
    logic fast_tick;
    logic slow_tick;

    modport owner (output srst, src_tick, reload, input cpu_tick, fast_tick, slow_tick);
    modport prescale (input srst, src_tick, reload, output cpu_tick);
    modport cycles (input srst, cpu_tick, output fast_tick, slow_tick);
endinterface : clock_tick_if
`default_nettype wire

//--- rtl/cycle_phase_gen.sv
// phase generator: fast strobe every 6 cpu ticks, slow every 12
// assumes cpu_tick is a one-cycle strobe on the same clock
`timescale 1ns/100ps
`default_nettype none
module cycle_phase_gen (
    input wire logic i_clk,
    clock_tick_if.cycles tick
);
    logic [clock_prescaler_pkg::PHASE_W-1:0] phase_r;
    logic fast_r;
    logic slow_r;

    always_ff @(posedge i_clk) begin
        if (tick.srst) begin
            phase_r <= '0;
        end else if (tick.cpu_tick) begin
            phase_r <= (phase_r == clock_prescaler_pkg::PHASE_LAST) ? '0 : phase_r + 4'h1;
        end
    end

    // [RL7] six ticks per cycle
    always_ff @(posedge i_clk) begin
        if (tick.srst) begin
            fast_r <= 1'b0;
            slow_r <= 1'b0;
        end else begin
            fast_r <= tick.cpu_tick && (phase_r == clock_prescaler_pkg::PHASE_MID ||
                                        phase_r == clock_prescaler_pkg::PHASE_LAST);
            slow_r <= tick.cpu_tick && (phase_r == clock_prescaler_pkg::PHASE_LAST);
        end
    end

    assign tick.fast_tick = fast_r;
    assign tick.slow_tick = slow_r;
endmodule : cycle_phase_gen
`default_nettype wire

//--- rtl/prescale_counter.sv
// reloadable prescaler: one cpu tick every reload_period source ticks
// assumes src_tick and reload come from logic on the same clock
`timescale 1ns/100ps
`default_nettype none
module prescale_counter (
    input wire logic i_clk,
    clock_tick_if.prescale tick
);
    logic [clock_prescaler_pkg::PERIOD_W-1:0] count_r;
    logic cpu_tick_r;

    // [RL18] reload at terminal count
    always_ff @(posedge i_clk) begin
        if (tick.srst) begin
            count_r <= clock_prescaler_pkg::PERIOD_ONE;
        end else if (tick.src_tick) begin
            if (count_r <= clock_prescaler_pkg::PERIOD_ONE) begin
                count_r <= clock_prescaler_pkg::reload_period(tick.reload);
            end else begin
                count_r <= count_r - clock_prescaler_pkg::PERIOD_ONE;
            end
        end
    end

    // [RL2] tick per period
    always_ff @(posedge i_clk) begin
        if (tick.srst) begin
            cpu_tick_r <= 1'b0;
        end else begin
            cpu_tick_r <= tick.src_tick && (count_r <= clock_prescaler_pkg::PERIOD_ONE);
        end
    end

    assign tick.cpu_tick = cpu_tick_r;
endmodule : prescale_counter
`default_nettype wire

//--- tb/clock_prescaler_speed_mode_asserts.sv
// checker: register port and strobe timing at the top ports
// assumes the bind in the bench top file
`timescale 1ns/100ps
`default_nettype none
module clock_prescaler_speed_mode_asserts (
    input wire logic i_clk,
    input wire logic i_srst,
    input wire logic i_wb_cyc,
    input wire logic i_wb_stb,
    input wire logic [clock_prescaler_pkg::WB_DAT_W-1:0] o_wb_dat,
    input wire logic o_wb_ack,
    input wire logic o_cpu_clk_en,
    input wire logic o_periph_clk_en,
    input wire logic o_machine_cycle,
    input wire logic o_timer0_tick
);
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (i_srst);
    sequence s_req;
        i_wb_cyc && i_wb_stb && !o_wb_ack;
    endsequence
    sequence s_ack_pulse;
        o_wb_ack ##1 !o_wb_ack;
    endsequence
    AST_WB_ANSWER: assert property (s_req |=> s_ack_pulse)
        else $error("ack not one cycle after request");
    AST_WB_NO_STRAY: assert property (o_wb_ack |-> $past(i_wb_cyc && i_wb_stb))
        else $error("ack without request");
    AST_RDAT_IDLE: assert property (!o_wb_ack |-> o_wb_dat == 32'h0)
        else $error("read data outside ack");
    AST_RDAT_BYTE: assert property (o_wb_ack |-> o_wb_dat[31:8] == 24'h0)
        else $error("read data above byte lane");
    AST_SAME_RATE: assert property (o_cpu_clk_en == o_periph_clk_en)
        else $error("cpu and peripheral strobes differ");
    AST_MC_SIX: assert property (o_machine_cycle |=> !o_machine_cycle [*5])
        else $error("machine cycle closer than six strobes");
    AST_PERIPH_SIX: assert property (o_timer0_tick |=> !o_timer0_tick [*5])
        else $error("timer tick closer than six strobes");
    AST_RESET_QUIET: assert property (disable iff (1'b0)
        i_srst |=> !o_cpu_clk_en && !o_machine_cycle && !o_wb_ack)
        else $error("strobe during reset");
endmodule : clock_prescaler_speed_mode_asserts
`default_nettype wire

//--- tb/clock_prescaler_speed_mode_bench.sv
// bench top: wishbone master, strobe spacing model, expected periods
// assumes design, checker and timing model compiled first
`timescale 1ns/100ps
`default_nettype none
module clock_prescaler_speed_mode_bench;
    logic i_clk = 1'b0, i_srst = 1'b1, i_hsb_double_speed = 1'b0;
    logic i_wb_cyc = 1'b0, i_wb_stb = 1'b0, i_wb_we = 1'b0;
    logic [11:0] i_wb_adr = 12'h000;
    logic [3:0] i_wb_sel = 4'h0;
    logic [31:0] i_wb_dat = 32'h0, o_wb_dat;
    logic o_wb_ack, o_cpu_clk_en, o_periph_clk_en, o_machine_cycle, o_double_speed;
    logic o_watchdog_tick, o_counter_array_tick, o_serial_fixed_tick, o_timer0_tick;
    logic o_timer1_tick, o_timer2_tick, o_serial_periph_tick;
    int err_total = 0, checks = 0;
    int gap [9];
    int bitpos [6] = '{6, 5, 4, 1, 2, 3};
    logic [15:0] lfsr = 16'he75f;
    wire logic [8:0] strb = {o_serial_periph_tick, o_timer2_tick, o_timer1_tick, o_timer0_tick,
        o_serial_fixed_tick, o_counter_array_tick, o_watchdog_tick, o_machine_cycle, o_cpu_clk_en};
    always #20 i_clk = ~i_clk;
    clock_prescaler_speed_mode clock_prescaler_speed_mode_i (.i_clk, .i_srst, .i_hsb_double_speed,
        .i_wb_cyc, .i_wb_stb, .i_wb_we, .i_wb_adr, .i_wb_sel, .i_wb_dat, .o_wb_dat, .o_wb_ack,
        .o_cpu_clk_en, .o_periph_clk_en, .o_machine_cycle, .o_double_speed, .o_watchdog_tick,
        .o_counter_array_tick, .o_serial_fixed_tick, .o_timer0_tick, .o_timer1_tick,
        .o_timer2_tick, .o_serial_periph_tick);
    core_timing_model core_timing_model_i (.i_clk, .i_strobe(strb), .o_gap(gap));
    ////////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            err_total++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic complete_run();
        $display("mismatches %0d comparisons %0d", err_total, checks);
        if (err_total == 0 && checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : complete_run
    task automatic wb(input logic we, input logic [7:0] idx, input logic [7:0] wd, output logic [7:0] rd);
        int n;
        n = 0;
        @(posedge i_clk);
        i_wb_cyc <= 1'b1;
        i_wb_stb <= 1'b1;
        i_wb_we <= we;
        i_wb_adr <= {2'b00, idx, 2'b00};
        i_wb_sel <= 4'h1;
        i_wb_dat <= {24'h0, wd};
        do begin
            @(posedge i_clk);
            n++;
        end while (o_wb_ack !== 1'b1 && n < 20);
        if (n >= 20) check(32'h1, 32'h0);
        rd = o_wb_dat[7:0];
        i_wb_cyc <= 1'b0;
        i_wb_stb <= 1'b0;
        @(posedge i_clk);
    endtask : wb
    task automatic wr(input logic [7:0] idx, input logic [7:0] wd);
        logic [7:0] d;
        wb(1'b1, idx, wd, d);
    endtask : wr
    task automatic rd(input logic [7:0] idx, output logic [7:0] v);
        wb(1'b0, idx, 8'h00, v);
    endtask : rd
    task automatic wait_strb(input int k, input int n);
        int t;
        t = 0;
        repeat (n) begin
            @(posedge i_clk);
            while (strb[k] !== 1'b1 && t < 40000) begin
                @(posedge i_clk);
                t++;
            end
        end
        if (t >= 40000) check(32'h1, 32'h0);
        @(posedge i_clk);
    endtask : wait_strb
    function automatic logic [15:0] lfsr_next(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr_next
    function automatic int exp_cpu(int rl, int ds, int byp);
        return ((rl == 255) ? 1 : 2 * (255 - rl)) * ((ds || byp) ? 1 : 2);
    endfunction : exp_cpu
    task automatic measure(input logic [7:0] rl, ctl, ext, byp, input int full);
        int p, t;
        logic [7:0] v;
        wr(8'h8e, byp);
        wr(8'haf, ext);
        wr(8'h97, rl);
        wr(8'h8f, ctl);
        t = 0;
        while (o_double_speed !== ctl[0] && t < 6) begin
            @(posedge i_clk);
            t++;
        end
        check(o_double_speed, ctl[0]);
        p = exp_cpu(rl, ctl[0], byp[0]);
        wait_strb(1, full ? 6 : 2);
        rd(8'h97, v);
        check(v, rl);
        check(gap[0], p);
        check(gap[1], 6 * p);
        if (full) begin
            rd(8'h8f, v);
            check(v, ctl);
            for (int k = 0; k < 6; k++) begin
                check(gap[k + 2], ((ctl[0] && ctl[bitpos[k]]) ? 12 : 6) * p);
            end
            check(gap[8], ((ctl[0] && ext[0]) ? 12 : 6) * p);
        end
    endtask : measure
    ////////////////////////////////////////////////////////////////
    initial begin
        logic [7:0] v;
        logic [7:0] rls [5];
        repeat (8) @(posedge i_clk);
        i_srst <= 1'b0;
        rd(8'h97, v);
        check(v, 8'hff);
        rd(8'h8f, v);
        check(v, 8'h00);
        rd(8'haf, v);
        check(v, 8'h00);
        rd(8'h10, v);
        check(v, 8'h00);
        wait_strb(1, 2);
        check(gap[0], 2);
        check(gap[1], 12);
        for (int ds = 0; ds < 2; ds++) begin
            lfsr = lfsr_next(lfsr);
            rls = '{8'h00, 8'h01, 8'hfe, 8'hff, {2'b11, lfsr[5:0]}};
            foreach (rls[i]) measure(rls[i], {7'h0, ds[0]}, 8'h00, 8'h00, 0);
        end
        // speed control writes keep bit 7 clear
        measure(8'hff, 8'h2b, 8'h01, 8'h00, 1);
        measure(8'hff, 8'h55, 8'h00, 8'h00, 1);
        measure(8'hff, 8'h7e, 8'h01, 8'h00, 1);
        measure({2'b11, lfsr[11:6]}, 8'h00, 8'h00, 8'h01, 1);
        rd(8'h8d, v);
        check(v, 8'h00);
        measure(8'h00, 8'h00, 8'h00, 8'h00, 0);
        wait_strb(0, 1);
        wr(8'h97, 8'hff);
        wait_strb(0, 1);
        check(gap[0], 1020);
        wait_strb(0, 2);
        check(gap[0], 2);
        i_hsb_double_speed <= 1'b1;
        i_srst <= 1'b1;
        repeat (8) @(posedge i_clk);
        i_srst <= 1'b0;
        rd(8'h8f, v);
        check(v, 8'h01);
        check(o_double_speed, 1'b1);
        wait_strb(1, 2);
        check(gap[0], 1);
        check(gap[1], 6);
        complete_run();
    end
    initial begin
        repeat (95000) @(posedge i_clk);
        err_total++;
        complete_run();
    end
endmodule : clock_prescaler_speed_mode_bench
bind clock_prescaler_speed_mode clock_prescaler_speed_mode_asserts clock_prescaler_speed_mode_asserts_i (
    .i_clk, .i_srst, .i_wb_cyc, .i_wb_stb, .o_wb_dat, .o_wb_ack, .o_cpu_clk_en, .o_periph_clk_en,
    .o_machine_cycle, .o_timer0_tick);
`default_nettype wire

//--- tb/core_timing_model.sv
// far-side timing model: spacing in cycles of each incoming strobe
// assumes one-cycle strobes on i_clk
`timescale 1ns/100ps
`default_nettype none
module core_timing_model (
    input wire logic i_clk,
    input wire logic [8:0] i_strobe,
    output var int o_gap [9]
);
    int cnt [9];
    always_ff @(posedge i_clk) begin
        for (int k = 0; k < 9; k++) begin
            if (i_strobe[k]) begin
                o_gap[k] <= cnt[k] + 1;
                cnt[k] <= 0;
            end else begin
                cnt[k] <= cnt[k] + 1;
            end
        end
    end
endmodule : core_timing_model
`default_nettype wire
